// file: light_prox_regs.svh
`ifndef LIGHT_PROX_REGS_SVH
`define LIGHT_PROX_REGS_SVH

// register byte addresses
`define ADDR_PROX_LOW_LO   8'h08
`define ADDR_PROX_LOW_HI   8'h09
`define ADDR_PROX_HIGH_LO  8'h0a
`define ADDR_PROX_HIGH_HI  8'h0b
`define ADDR_FILTER        8'h0c
`define ADDR_WAIT_CFG      8'h0d
`define ADDR_PULSE_COUNT   8'h0e
`define ADDR_ANALOG        8'h0f
`define ADDR_PART_ID       8'h12
`define ADDR_STATUS        8'h13

// field positions
`define PROX_PERS_MSB      7
`define PROX_PERS_LSB      4
`define CLEAR_PERS_MSB     3
`define CLEAR_PERS_LSB     0
`define LONG_WAIT_POS      1
`define DRIVE_MSB          7
`define DRIVE_LSB          6
`define DIODE_MSB          5
`define DIODE_LSB          4
`define GAIN_MSB           1
`define GAIN_LSB           0
`define ST_PROX_IRQ_POS    5
`define ST_CLEAR_IRQ_POS   4
`define ST_PROX_VALID_POS  1
`define ST_COLOUR_VALID_POS 0

// reset values
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000
// arbitrary neutral identity value
`define PART_ID_DEFAULT    8'h5a

// timing
`define STEP_TIME_NS       2400000
`define CLK_PERIOD_NS      8
`define LONG_WAIT_FACTOR   4'hc
`define SHORT_WAIT_FACTOR  4'h1
`define CODE_SPAN          9'h100
`define PULSE_HALF_CYCLES  3'h4

`endif

// file: light_prox_pkg.sv
package light_prox_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INTEG = 2'b01,
        ST_PROX  = 2'b10,
        ST_WAIT  = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lnk_req_s;

    typedef struct packed {
        logic [1:0] drive;
        logic [1:0] diode;
        logic [1:0] gain;
    } analog_ctl_s;

endpackage

// file: toggle_sync.sv
`timescale 1ns/10ps
// carries an event across clocks as a toggle; pulse is one dest cycle
module toggle_sync (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic tog_i,
    output wire logic pulse_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q feeds sync_q only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= tog_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign pulse_o = sync_q ^ last_q;
endmodule // toggle_sync

// file: pers_filter.sv
`timescale 1ns/10ps
// counts uninterrupted runs of out-of-range results
module pers_filter (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       result_valid_i,
    input  wire logic       out_of_range_i,
    input  wire logic [5:0] need_i,
    output wire logic       hit_o
);
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic       hit_q;
    logic       hit_d;
    wire        every   = (need_i == 6'h00);
    // saturate so a long run never wraps back below the goal
    wire  [5:0] cnt_inc = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;

    // next count and hit for one finished result
    always_comb begin
        cnt_d = cnt_q;
        hit_d = 1'b0;
        if (result_valid_i) begin
            if (every) begin
                hit_d = 1'b1;
            end else if (out_of_range_i) begin
                cnt_d = cnt_inc;
                hit_d = (cnt_inc >= need_i);
            end else begin
                cnt_d = 6'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q <= 6'h00;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign hit_o = hit_q;
endmodule // pers_filter

// file: light_prox_irq_config_regs.sv
// Notes on behaviour
// - proximity low and high thresholds are 16 bits, lower byte first.
// - proximity result below low or above high threshold is out of range.
// - proximity and clear results have separate persistence filters.
// - proximity persistence zero interrupts after every proximity cycle.
// - proximity persistence N needs N consecutive out-of-range results.
// - clear persistence zero interrupts after every colour cycle.
// - clear codes 1 to 3 need 1 to 3 consecutive results.
// - clear codes 4 to 15 need 5 to 60 results, steps of five.
// - long-wait bit multiplies the wait period by twelve.
// - proximity cycle runs right after each colour cycle when enabled.
// - colour integration time spaces proximity cycles even colour disabled.
// - each proximity cycle emits exactly the programmed LED pulse count.
// - control register drives LED drive level and colour gain.
// - diode select picks the proximity detector; code zero unused.
// - identity register is read-only with a fixed value.
// - status register is read-only; writes change nothing.
// - status bits 5 and 4 show pending proximity and clear interrupts.
// - status bit 1 sets after a cycle completes with colour enabled.
// - status bit 0 sets when colour integration completes.
// - interrupt clear input clears pending flags while it is held high.
// - interrupts only generated while their enables are set.
// - wait period counts in 2.4 ms steps.
`timescale 1ns/10ps
`include "light_prox_regs.svh"
module light_prox_irq_config_regs
    import light_prox_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS,
    parameter logic [7:0]  PART_ID     = `PART_ID_DEFAULT // arbitrary value
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       lnk_clk_i,
    input  wire logic       lnk_valid_i,
    input  wire lnk_req_s   lnk_req_i,
    output wire logic       lnk_ready_o,
    output wire logic       lnk_rvalid_o,
    output wire logic [7:0] lnk_rdata_o,
    input  wire logic       colour_measure_enable_i,
    input  wire logic       prox_enable_i,
    input  wire logic       wait_enable_i,
    input  wire logic       prox_irq_enable_i,
    input  wire logic       colour_irq_enable_i,
    input  wire logic       irq_clear_i,
    input  wire logic [7:0] colour_integration_time_i,
    input  wire logic [7:0] wait_period_i,
    input  wire logic [15:0] clear_result_i,
    input  wire logic [15:0] clear_low_thresh_i,
    input  wire logic [15:0] clear_high_thresh_i,
    input  wire logic [15:0] prox_result_i,
    output wire logic       irq_o,
    output wire logic       led_pulse_o,
    output wire logic       prox_cycle_o,
    output wire logic       colour_integrating_o,
    output wire logic [1:0] led_drive_level_o,
    output wire logic [1:0] prox_detector_select_o,
    output wire logic [1:0] colour_gain_o
);
    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    // number of 2.4 ms steps a two's complement code stands for
    function automatic logic [8:0] steps_of(input logic [7:0] code);
        return `CODE_SPAN - {1'b0, code};
    endfunction

    // consecutive results the clear-channel code asks for
    function automatic logic [5:0] clear_need(input logic [3:0] code);
        if (code <= 4'h3) begin
            return {2'b00, code};
        end
        return 6'(({2'b00, code} - 6'h03) * 6'h05);
    endfunction

    // put one byte into a 16-bit threshold
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic [7:0]  data,
                                             input logic        upper);
        return upper ? {data, old[7:0]} : {old[15:8], data};
    endfunction

    // ---------------- link domain ----------------
    logic     lrst_meta_q;
    logic     lrst_q;
    logic     lnk_ready_q;
    logic     lnk_rvalid_q;
    logic [7:0] lnk_rdata_q;
    logic     req_tog_q;
    lnk_req_s hold_q;
    wire      ack_pulse;
    logic [7:0] rdata_q;

    // reset brought into the link clock; meta flop feeds only lrst_q
    always_ff @(posedge lnk_clk_i) begin
        lrst_meta_q <= srst_i;
        lrst_q      <= lrst_meta_q;
    end

    // request is held steady until the core answers, so the bundle
    // crosses safely under the toggle handshake
    always_ff @(posedge lnk_clk_i) begin
        if (lrst_q) begin
            lnk_ready_q <= 1'b1;
            req_tog_q   <= 1'b0;
            hold_q      <= '0;
        end else if (lnk_valid_i && lnk_ready_q) begin
            lnk_ready_q <= 1'b0;
            req_tog_q   <= ~req_tog_q;
            hold_q      <= lnk_req_i;
        end else if (ack_pulse) begin
            lnk_ready_q <= 1'b1;
        end
    end

    // answer back on the link, rdata_q is stable once ack arrives
    always_ff @(posedge lnk_clk_i) begin
        if (lrst_q) begin
            lnk_rvalid_q <= 1'b0;
            lnk_rdata_q  <= `RST_BYTE;
        end else begin
            lnk_rvalid_q <= ack_pulse;
            if (ack_pulse) begin
                lnk_rdata_q <= rdata_q;
            end
        end
    end

    // ---------------- core domain ----------------
    wire         req_pulse;
    logic        ack_tog_q;
    logic [15:0] prox_low_q;
    logic [15:0] prox_high_q;
    logic [7:0]  filter_q;
    logic        long_wait_q;
    logic [7:0]  pulse_count_q;
    analog_ctl_s analog_q;
    logic        prox_flag_q;
    logic        clear_flag_q;
    logic        prox_valid_q;
    logic        colour_valid_q;
    logic        irq_q;

    toggle_sync u_req_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .tog_i   (req_tog_q),
        .pulse_o (req_pulse)
    );

    toggle_sync u_ack_sync (
        .clk_i   (lnk_clk_i),
        .srst_i  (lrst_q),
        .tog_i   (ack_tog_q),
        .pulse_o (ack_pulse)
    );

    // address decode; id and status have no write strobe at all
    wire wr        = req_pulse && hold_q.write;
    wire [7:0] adr = hold_q.addr;
    wire [7:0] wd  = hold_q.wdata;
    wire wr_low    = wr && (adr == `ADDR_PROX_LOW_LO ||
                            adr == `ADDR_PROX_LOW_HI);
    wire wr_high   = wr && (adr == `ADDR_PROX_HIGH_LO ||
                            adr == `ADDR_PROX_HIGH_HI);
    wire wr_filter = wr && (adr == `ADDR_FILTER);
    wire wr_wait   = wr && (adr == `ADDR_WAIT_CFG);
    wire wr_pulse  = wr && (adr == `ADDR_PULSE_COUNT);
    wire wr_analog = wr && (adr == `ADDR_ANALOG);
    wire upper     = adr[0];

    // status byte, reserved bits read as zero
    wire [7:0] status_byte =
        ({7'h00, prox_flag_q}    << `ST_PROX_IRQ_POS)     |
        ({7'h00, clear_flag_q}   << `ST_CLEAR_IRQ_POS)    |
        ({7'h00, prox_valid_q}   << `ST_PROX_VALID_POS)   |
        ({7'h00, colour_valid_q} << `ST_COLOUR_VALID_POS);
    wire [7:0] analog_byte = {analog_q.drive, analog_q.diode,
                              2'b00, analog_q.gain};
    wire [7:0] wait_byte   = {7'h00, long_wait_q} << `LONG_WAIT_POS;

    // read mux; unmapped addresses read zero
    wire [7:0] rd_mux =
        (adr == `ADDR_PROX_LOW_LO)  ? prox_low_q[7:0]   :
        (adr == `ADDR_PROX_LOW_HI)  ? prox_low_q[15:8]  :
        (adr == `ADDR_PROX_HIGH_LO) ? prox_high_q[7:0]  :
        (adr == `ADDR_PROX_HIGH_HI) ? prox_high_q[15:8] :
        (adr == `ADDR_FILTER)       ? filter_q          :
        (adr == `ADDR_WAIT_CFG)     ? wait_byte         :
        (adr == `ADDR_PULSE_COUNT)  ? pulse_count_q     :
        (adr == `ADDR_ANALOG)       ? analog_byte       :
        (adr == `ADDR_PART_ID)      ? PART_ID           :
        (adr == `ADDR_STATUS)       ? status_byte       :
        `RST_BYTE;

    // capture read data and answer every request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q   <= `RST_BYTE;
            ack_tog_q <= 1'b0;
        end else if (req_pulse) begin
            rdata_q   <= rd_mux;
            ack_tog_q <= ~ack_tog_q;
        end
    end

    // thresholds assembled from byte writes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prox_low_q  <= `RST_WORD;
            prox_high_q <= `RST_WORD;
        end else begin
            if (wr_low) prox_low_q <= put_byte(prox_low_q, wd, upper);
            if (wr_high) prox_high_q <= put_byte(prox_high_q, wd, upper);
        end
    end

    // configuration bytes; reserved bits are simply not stored
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            filter_q      <= `RST_BYTE;
            long_wait_q   <= 1'b0;
            pulse_count_q <= `RST_BYTE;
            analog_q      <= '0;
        end else begin
            if (wr_filter) filter_q <= wd;
            if (wr_wait) long_wait_q <= wd[`LONG_WAIT_POS];
            if (wr_pulse) pulse_count_q <= wd;
            if (wr_analog) begin
                analog_q.drive <= wd[`DRIVE_MSB:`DRIVE_LSB];
                analog_q.diode <= wd[`DIODE_MSB:`DIODE_LSB];
                analog_q.gain  <= wd[`GAIN_MSB:`GAIN_LSB];
            end
        end
    end

    // ---------------- measurement sequencer ----------------
    seq_state_e state_q;
    seq_state_e state_d;
    logic [STEP_W-1:0] step_q;
    logic [11:0] unit_q;
    logic [7:0]  pulse_left_q;
    logic [2:0]  half_q;
    logic        led_q;
    logic        colour_done;
    logic        prox_done;

    wire run = colour_measure_enable_i || prox_enable_i;
    wire [3:0]  wait_factor = long_wait_q ? `LONG_WAIT_FACTOR
                                          : `SHORT_WAIT_FACTOR;
    wire [11:0] wait_units  = 12'({3'b000, steps_of(wait_period_i)} *
                                  {8'h00, wait_factor});
    wire [11:0] integ_units = {3'b000,
                               steps_of(colour_integration_time_i)};
    wire [11:0] unit_goal   = (state_q == ST_WAIT) ? wait_units
                                                   : integ_units;
    wire step_end  = (step_q == STEP_W'(STEP_CYCLES - 1));
    wire unit_end  = step_end && (unit_q == unit_goal - 12'h001);
    wire half_end  = (half_q == `PULSE_HALF_CYCLES - 3'h1);
    wire pulses_done = (pulse_left_q == 8'h00) && !led_q;
    wire timer_clr = (state_d != state_q);
    wire prox_enter = (state_d == ST_PROX) && (state_q != ST_PROX);
    wire seq_state_e after_prox = wait_enable_i ? ST_WAIT : ST_INTEG;

    // integration always paced by the colour time, colour on or off
    always_comb begin
        state_d     = state_q;
        colour_done = 1'b0;
        prox_done   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (run) state_d = ST_INTEG;
            end
            ST_INTEG: begin
                if (!run) begin
                    state_d = ST_IDLE;
                end else if (unit_end) begin
                    colour_done = colour_measure_enable_i;
                    if (prox_enable_i) state_d = ST_PROX;
                    else state_d = after_prox;
                end
            end
            ST_PROX: begin
                if (!run) begin
                    state_d = ST_IDLE;
                end else if (pulses_done && !prox_enter) begin
                    prox_done = 1'b1;
                    state_d   = after_prox;
                end
            end
            ST_WAIT: begin
                if (!run) state_d = ST_IDLE;
                else if (unit_end) state_d = ST_INTEG;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // step and unit timers restart on every state change
    always_ff @(posedge clk_i) begin
        if (srst_i || timer_clr) begin
            step_q <= '0;
            unit_q <= 12'h000;
        end else begin
            step_q <= step_end ? '0 : step_q + STEP_W'(1);
            if (step_end) unit_q <= unit_q + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) state_q <= ST_IDLE;
        else state_q <= state_d;
    end

    // led pulse train: high then low per pulse, count taken at entry
    always_ff @(posedge clk_i) begin
        if (srst_i || prox_enter) begin
            pulse_left_q <= prox_enter ? pulse_count_q : 8'h00;
            half_q       <= 3'h0;
            led_q        <= 1'b0;
        end else if (state_q == ST_PROX) begin
            half_q <= half_end ? 3'h0 : half_q + 3'h1;
            if (half_end && led_q) begin
                led_q        <= 1'b0;
                pulse_left_q <= pulse_left_q - 8'h01;
            end else if (half_end && pulse_left_q != 8'h00) begin
                led_q <= 1'b1;
            end
        end
    end

    // ---------------- thresholds and persistence ----------------
    wire prox_oor  = (prox_result_i < prox_low_q) ||
                     (prox_result_i > prox_high_q);
    wire clear_oor = (clear_result_i < clear_low_thresh_i) ||
                     (clear_result_i > clear_high_thresh_i);
    wire prox_hit;
    wire clear_hit;

    // two independent filters, one per channel
    pers_filter u_prox_filter (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .result_valid_i (prox_done),
        .out_of_range_i (prox_oor),
        .need_i         ({2'b00,
                          filter_q[`PROX_PERS_MSB:`PROX_PERS_LSB]}),
        .hit_o          (prox_hit)
    );

    pers_filter u_clear_filter (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .result_valid_i (colour_done),
        .out_of_range_i (clear_oor),
        .need_i         (clear_need(
                          filter_q[`CLEAR_PERS_MSB:`CLEAR_PERS_LSB])),
        .hit_o          (clear_hit)
    );

    // flags: a new hit in the clear cycle wins over the clear
    wire prox_set  = prox_hit && prox_irq_enable_i;
    wire clear_set = clear_hit && colour_irq_enable_i;
    wire cycle_done = colour_done || prox_done;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prox_flag_q  <= 1'b0;
            clear_flag_q <= 1'b0;
        end else begin
            prox_flag_q  <= prox_set  || (prox_flag_q  && !irq_clear_i);
            clear_flag_q <= clear_set || (clear_flag_q && !irq_clear_i);
        end
    end

    // valid bits drop when colour measurement is switched off
    always_ff @(posedge clk_i) begin
        if (srst_i || !colour_measure_enable_i) begin
            prox_valid_q   <= 1'b0;
            colour_valid_q <= 1'b0;
        end else begin
            if (cycle_done) prox_valid_q <= 1'b1;
            if (colour_done) colour_valid_q <= 1'b1;
        end
    end

    // interrupt level; enables gate it live, so masking drops irq_o one cycle later
    always_ff @(posedge clk_i) begin
        if (srst_i) irq_q <= 1'b0;
        else irq_q <= (prox_flag_q && prox_irq_enable_i) ||
                      (clear_flag_q && colour_irq_enable_i);
    end

    // outputs straight from flops, except prox_cycle_o and colour_integrating_o, decoded from state_q
    assign lnk_ready_o            = lnk_ready_q;
    assign lnk_rvalid_o           = lnk_rvalid_q;
    assign lnk_rdata_o            = lnk_rdata_q;
    assign irq_o                  = irq_q;
    assign led_pulse_o            = led_q;
    assign prox_cycle_o           = (state_q == ST_PROX);
    assign colour_integrating_o   = (state_q == ST_INTEG);
    assign led_drive_level_o      = analog_q.drive;
    assign prox_detector_select_o = analog_q.diode;
    assign colour_gain_o          = analog_q.gain;
endmodule // light_prox_irq_config_regs

// file: host_link.sv
`timescale 1ns/10ps
// host end of the register link: one request at a time, held until taken
module host_link
    import light_prox_pkg::*;
(
    input  wire logic       lnk_clk_i,
    input  wire logic       lnk_ready_i,
    input  wire logic       lnk_rvalid_i,
    input  wire logic [7:0] lnk_rdata_i,
    output logic            lnk_valid_o,
    output lnk_req_s        lnk_req_o
);
    initial begin
        lnk_valid_o = 1'b0;
        lnk_req_o   = '0;
    end
    // once taken the request lines are inverted, so stale bits never
    // pass for a fresh request
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge lnk_clk_i);
        lnk_valid_o <= 1'b1;
        lnk_req_o   <= '{w, a, d};
        do @(posedge lnk_clk_i); while (lnk_ready_i !== 1'b1);
        lnk_valid_o <= 1'b0;
        lnk_req_o   <= ~lnk_req_o;
        do begin
            @(posedge lnk_clk_i);
            n++;
        end while (lnk_rvalid_i !== 1'b1 && n < 40);
        q = lnk_rdata_i;
    endtask
endmodule // host_link

// file: light_prox_checker_asserts.sv
`timescale 1ns/10ps
// link handshake, led pulse and irq timing seen at the top ports
module light_prox_checker (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic lnk_clk_i,
    input wire logic lnk_valid_i,
    input wire logic lnk_ready_o,
    input wire logic lnk_rvalid_o,
    input wire logic prox_enable_i,
    input wire logic prox_irq_enable_i,
    input wire logic colour_irq_enable_i,
    input wire logic irq_clear_i,
    input wire logic irq_o,
    input wire logic led_pulse_o,
    input wire logic prox_cycle_o,
    input wire logic colour_integrating_o
);
    // a taken request drops ready and is answered in bounded time
    link_answer_a: assert property (@(posedge lnk_clk_i)
        disable iff (srst_i) lnk_valid_i && lnk_ready_o |=>
        !lnk_ready_o ##[1:20] lnk_rvalid_o) else $error("no answer");
    rvalid_pulse_a: assert property (@(posedge lnk_clk_i)
        disable iff (srst_i) lnk_rvalid_o |=> !lnk_rvalid_o)
        else $error("answer too long");
    // four core cycles high, then at least four low
    pulse_width_a: assert property (@(posedge clk_i)
        disable iff (srst_i) $rose(led_pulse_o) |=>
        led_pulse_o [*3] ##1 !led_pulse_o [*4]) else $error("bad pulse");
    pulse_place_a: assert property (@(posedge clk_i)
        disable iff (srst_i) led_pulse_o |-> prox_cycle_o)
        else $error("pulse outside cycle");
    // a proximity cycle only follows integration, and only when enabled
    prox_order_a: assert property (@(posedge clk_i)
        disable iff (srst_i) $rose(prox_cycle_o) |->
        $past(colour_integrating_o)) else $error("cycle out of order");
    prox_gate_a: assert property (@(posedge clk_i)
        disable iff (srst_i) $rose(prox_cycle_o) |->
        $past(prox_enable_i)) else $error("cycle while disabled");
    // irq is a registered level: gated by enables; while enabled, dropped only by clear
    irq_gate_a: assert property (@(posedge clk_i)
        disable iff (srst_i) irq_o |->
        $past(prox_irq_enable_i) || $past(colour_irq_enable_i))
        else $error("irq while disabled");
    irq_hold_a: assert property (@(posedge clk_i)
        disable iff (srst_i) $fell(irq_o) |->
        $past(irq_clear_i) || $past(irq_clear_i, 2))
        else $error("irq dropped early");
endmodule // light_prox_checker

bind light_prox_irq_config_regs light_prox_checker u_chk (.clk_i, .srst_i,
    .lnk_clk_i, .lnk_valid_i, .lnk_ready_o, .lnk_rvalid_o, .prox_enable_i,
    .prox_irq_enable_i, .colour_irq_enable_i, .irq_clear_i, .irq_o,
    .led_pulse_o, .prox_cycle_o, .colour_integrating_o);

// file: light_prox_irq_config_regs_tb.sv
`timescale 1ns/10ps
`include "light_prox_regs.svh"
module light_prox_irq_config_regs_tb
    import light_prox_pkg::*;
;
    logic        clk_i = 1'b0, srst_i = 1'b1, lnk_clk_i = 1'b0;
    logic        colour_measure_enable_i = 1'b0, prox_enable_i = 1'b0;
    logic        prox_irq_enable_i = 1'b0, colour_irq_enable_i = 1'b0;
    logic        irq_clear_i = 1'b0, lnk_valid_i, wait_enable_i = 1'b0;
    logic [15:0] clear_result_i = 16'h0180, prox_result_i = 16'h0200;
    lnk_req_s    lnk_req_i;
    logic        lnk_ready_o, lnk_rvalid_o, irq_o, led_pulse_o;
    logic        prox_cycle_o, colour_integrating_o;
    logic [7:0]  lnk_rdata_o;
    logic [1:0]  led_drive_level_o, prox_detector_select_o, colour_gain_o;
    int          num_errors = 0, comparisons = 0, cyc = 0;
    int          pfall = 0, cfall = 0, lcnt = 0, k;
    // register image: address, byte written, byte read back
    logic [7:0]  a_t[10] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
                             8'h0e, 8'h0f, 8'h12, 8'h13};
    logic [7:0]  d_t[10] = '{8'h40, 8'h01, 8'h80, 8'h02, 8'h00, 8'h02,
                             8'h03, 8'h63, 8'hff, 8'hff};
    logic [7:0]  e_t[10] = '{8'h40, 8'h01, 8'h80, 8'h02, 8'h00, 8'h02,
                             8'h03, 8'h63, `PART_ID_DEFAULT, 8'h00};
    // persistence runs: filter byte, out-of-range value, cycles to irq
    logic [7:0]  f_t[5] = '{8'h21, 8'hf1, 8'h13, 8'h14, 8'h1f};
    logic [15:0] v_t[5] = '{16'h013f, 16'h0281, 16'h00ff, 16'h0201, 16'h0000};
    int          n_t[5] = '{2, 15, 3, 5, 60};

    light_prox_irq_config_regs #(.STEP_CYCLES(4)) u_dut (.clk_i, .srst_i,
        .lnk_clk_i, .lnk_valid_i, .lnk_req_i, .lnk_ready_o, .lnk_rvalid_o,
        .lnk_rdata_o, .colour_measure_enable_i, .prox_enable_i,
        .wait_enable_i, .prox_irq_enable_i, .colour_irq_enable_i,
        .irq_clear_i, .colour_integration_time_i(8'hff),
        .wait_period_i(8'hff), .clear_result_i,
        .clear_low_thresh_i(16'h0100), .clear_high_thresh_i(16'h0200),
        .prox_result_i, .irq_o, .led_pulse_o, .prox_cycle_o,
        .colour_integrating_o, .led_drive_level_o,
        .prox_detector_select_o, .colour_gain_o);
    host_link u_host (.lnk_clk_i, .lnk_ready_i(lnk_ready_o),
        .lnk_rvalid_i(lnk_rvalid_o), .lnk_rdata_i(lnk_rdata_o),
        .lnk_valid_o(lnk_valid_i), .lnk_req_o(lnk_req_i));

    always #4 clk_i = ~clk_i;
    // link clock offset so its edges never line up with the core clock
    initial begin
        #2.3;
        forever #15 lnk_clk_i = ~lnk_clk_i;
    end
    // cycle ends and led pulses counted off the outputs
    always @(negedge prox_cycle_o) pfall++;
    always @(negedge colour_integrating_o) cfall++;
    always @(posedge led_pulse_o) lcnt++;
    // hang guard, well above the longest persistence run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        logic [7:0] q;
        u_host.xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 4000 && irq_o !== 1'b1; n++) @(posedge clk_i);
    endtask
    // clear at a cycle boundary, then hold one result out of range; old
    // in-range results must leave the count at zero
    task automatic persist(input int i);
        wr(8'h0c, f_t[i]);
        if (i < 2) @(negedge prox_cycle_o);
        else @(negedge colour_integrating_o);
        @(posedge clk_i);
        irq_clear_i <= 1'b1;
        if (i < 2) prox_result_i <= v_t[i];
        else clear_result_i <= v_t[i];
        pfall = 0;
        cfall = 0;
        @(posedge clk_i);
        irq_clear_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({7'h00, irq_o}, 8'h00);
        wait_irq();
        chk(i < 2 ? pfall[7:0] : cfall[7:0], n_t[i][7:0]);
        prox_result_i <= 16'h0200;
        clear_result_i <= 16'h0180;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge lnk_clk_i);
        for (int i = 0; i < 8; i++)
            rd(a_t[i], 8'h00);
        for (int i = 0; i < 10; i++)
            wr(a_t[i], d_t[i]);
        wr(8'h10, 8'hff);
        for (int i = 0; i < 10; i++)
            rd(a_t[i], e_t[i]);
        rd(8'h10, 8'h00);
        chk({2'b00, led_drive_level_o, prox_detector_select_o,
             colour_gain_o}, 8'h1b);
        colour_measure_enable_i <= 1'b1;
        prox_enable_i <= 1'b1;
        prox_irq_enable_i <= 1'b1;
        colour_irq_enable_i <= 1'b1;
        wait_irq();
        @(negedge prox_cycle_o);
        k = lcnt;
        @(negedge prox_cycle_o);
        chk(8'(lcnt - k), 8'h03);
        rd(8'h13, 8'h33);
        for (int i = 0; i < 5; i++)
            persist(i);
        colour_measure_enable_i <= 1'b0;
        wait_enable_i <= 1'b1;
        k = pfall;
        repeat (200) @(posedge clk_i);
        chk({7'h00, pfall - k inside {[2:3]}}, 8'h01);
        end_sim();
    end
endmodule // light_prox_irq_config_regs_tb
